//--- hsi_params.svh
// Addresses, offsets, codes and reset values of the host status block
`ifndef HSI_PARAMS_SVH
`define HSI_PARAMS_SVH
// Local bus byte addresses
`define HSI_LB_WARM_RESET   32'h1ffa_0014
`define HSI_LB_NMI          32'h1ffa_001c
`define HSI_LB_ATTENTION    32'h1ffa_2004
`define HSI_LB_CONTROL      32'h1ffa_2008
`define HSI_LB_INT_STATUS   32'h1ffa_200c
`define HSI_LB_CMD_BUSY     32'h1ffa_2010
`define HSI_LB_SOURCE_ID    32'h1ffa_2014
// Host port offsets from the adapter base
`define HSI_HO_CMD_LAST     4'h3
`define HSI_HO_ATTENTION    4'h4
`define HSI_HO_CONTROL      4'h5
`define HSI_HO_INT_STATUS   4'h6
`define HSI_HO_CMD_BUSY     4'h7
`define HSI_HO_NMI          4'hb
// Control port bit positions
`define HSI_CTL_CMD_RESET   7
`define HSI_CTL_CLR_BY_READ 6
`define HSI_CTL_REJ_RELEASE 5
`define HSI_CTL_IRQ_ENABLE  0
// Attention codes and rejection code
`define HSI_ATTENTION_PORT_MOVE_MODE  4'hd
`define HSI_ATTENTION_PORT_EOI        8'he0
`define HSI_REJ_WATCHDOG    3'h1
// Reset values
`define HSI_COMMAND_BUSY_STATUS_RESET      8'h01
`define HSI_CTL_CMD_RESET_V 8'h80
`define HSI_READ_IN_RESET   8'hff
// Local interrupt codes, lower code wins
`define HSI_SRC_NMI         3'h0
`define HSI_SRC_GENERAL     3'h1
`define HSI_SRC_EOT         3'h2
`define HSI_SRC_ATTENTION   3'h3
`define HSI_SRC_PARITY      3'h4
`define HSI_SRC_CHAN1       3'h5
`define HSI_SRC_CHAN2       3'h6
`define HSI_NUM_SRC         7
`define HSI_IRQ_IDLE        4'hf
`endif

//--- hsi_pkg.sv
// Types shared by the host status block
package hsi_pkg;
  // Command busy status port layout
  typedef struct packed {
    logic [2:0] rejection_code;
    logic       reject_flag;
    logic [1:0] device_dependent_bits;
    logic       interrupt_valid_flag;
    logic       busy;
  } hsi_command_busy_status_s;

  // Local bus access
  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } hsi_lb_req_s;

  typedef logic [6:0] hsi_src_t;
endpackage

//--- hsi_host_status.sv
// Host status ports, source id register and local interrupt encoder
`timescale 1ns/1ps
`default_nettype none
`include "hsi_params.svh"

// Function
// - Watchdog timeout loads rejection code 001 into top three status bits.
// - Reject flag blocks host attention and command writes except code D.
// - Interrupt-valid flag raises host interrupt; status in INTERRUPT_STATUS_PORT or code bits.
// - Valid flag clears on E0 attention, or instead on status read if selected.
// - Attention write sets busy; busy blocks host attention and command writes, except code D while the reject flag is set.
// - Self-clearing reject-release bit clears busy and reject flags.
// - Power-up status reads 01; command reset clears reject, valid, sets busy.
// - Attention code D sets source id bit indexed by device number.
// - Source id bits set only by host; local write zero clears, one ignored.
// - General interrupt ORs bits 7-0; end-of-transfer ORs bits 15-8.
// - Source id register zero after power-up and command reset.
// - Warm-reset flag set by command reset, cleared by host bus reset.
// - Nonzero host NMI write sets status and requests local code 0.
// - Local NMI register read clears status and its interrupt.
// - Seven local sources present as one encoded value on four lines.
// - Encoded interrupt held until cleared; others wait pending.
// - After clear latch pending batch; new ones latch once batch drained.
// - Simultaneous interrupts served in encoded value order.
// - Pending NMI always goes next, overriding order and batches.
// - NMI, parity clear on status read; attention on local attention read.
// - General and end-of-transfer clear on source id write, then re-raise.
// - Channel interrupt clears on read of that channel status register.
module hsi_host_status (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               host_bus_rst,
  input  wire logic [3:0]         host_addr,
  input  wire logic               host_wr,
  input  wire logic               host_rd,
  input  wire logic [7:0]         host_wdata,
  output logic      [7:0]         host_rdata,
  output logic                    host_irq,
  output logic                    cmd_reset_out,
  output logic      [31:0]        cmd_word,
  input  wire hsi_pkg::hsi_lb_req_s lb_req,
  output logic      [31:0]        lb_rdata,
  input  wire logic               watchdog_evt,
  input  wire logic               parity_evt,
  input  wire logic               parity_stat_rd,
  input  wire logic [1:0]         chan_evt,
  input  wire logic [1:0]         chan_stat_rd,
  output logic      [3:0]         irq_lines,
  output logic                    irq_active
);

  hsi_pkg::hsi_command_busy_status_s command_busy_status_q, command_busy_status_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [7:0]  attention_port_q, attention_port_d;
  logic [7:0]  isp_q, isp_d;
  logic [31:0] cmd_q, cmd_d;
  logic [15:0] sir_q, sir_d;
  logic        rs_q, rs_d;
  logic        nmi_q, nmi_d;
  logic [7:0]  hrd_q, hrd_d;
  logic [31:0] lrd_q, lrd_d;

  logic cmd_rst;
  logic attention_port_wr, attention_port_ok, cmd_wr_ok, move_mode, nmi_set;
  logic lb_wr_command_busy_status, lb_wr_sir, lb_wr_isp;
  logic lb_rd_nmi, lb_rd_attention_port;

  // Host and local access decode
  always_comb
  begin
    cmd_rst    = ctl_q[`HSI_CTL_CMD_RESET];
    attention_port_wr    = host_wr && host_addr == `HSI_HO_ATTENTION;
    move_mode  = host_wdata[7:4] == `HSI_ATTENTION_PORT_MOVE_MODE;
    // Move mode passes a reject so the host can still post work
    attention_port_ok    = attention_port_wr && !cmd_rst &&
                 ((!command_busy_status_q.busy && !command_busy_status_q.reject_flag) ||
                  (command_busy_status_q.reject_flag && move_mode));
    cmd_wr_ok  = host_wr && host_addr <= `HSI_HO_CMD_LAST && !cmd_rst &&
                 !command_busy_status_q.busy && !command_busy_status_q.reject_flag;
    nmi_set    = host_wr && host_addr == `HSI_HO_NMI && !cmd_rst &&
                 host_wdata != 8'h00;
    lb_wr_command_busy_status = lb_req.wr && lb_req.addr == `HSI_LB_CMD_BUSY;
    lb_wr_sir  = lb_req.wr && lb_req.addr == `HSI_LB_SOURCE_ID;
    lb_wr_isp  = lb_req.wr && lb_req.addr == `HSI_LB_INT_STATUS;
    lb_rd_nmi  = lb_req.rd && lb_req.addr == `HSI_LB_NMI;
    lb_rd_attention_port = lb_req.rd && lb_req.addr == `HSI_LB_ATTENTION;
  end

  // Host-facing registers: control, attention, command, status
  always_comb
  begin
    ctl_d  = ctl_q;
    attention_port_d = attention_port_q;
    cmd_d  = cmd_q;
    isp_d  = lb_wr_isp ? lb_req.wdata[7:0] : isp_q;
    command_busy_status_d = command_busy_status_q;
    if (host_wr && host_addr == `HSI_HO_CONTROL)
      ctl_d = host_wdata;
    else
      ctl_d[`HSI_CTL_REJ_RELEASE] = 1'b0; // Self-clearing
    if (cmd_wr_ok)
      cmd_d[8*host_addr[1:0] +: 8] = host_wdata;
    if (attention_port_ok)
      attention_port_d = host_wdata;
    // Lowest priority first: host-side clears, then local write, then attention and watchdog sets
    if (ctl_q[`HSI_CTL_REJ_RELEASE])
    begin
      command_busy_status_d.busy        = 1'b0;
      command_busy_status_d.reject_flag = 1'b0;
    end
    if (attention_port_ok && host_wdata == `HSI_ATTENTION_PORT_EOI &&
        !ctl_q[`HSI_CTL_CLR_BY_READ])
      command_busy_status_d.interrupt_valid_flag = 1'b0;
    if (host_rd && host_addr == `HSI_HO_CMD_BUSY && !cmd_rst &&
        ctl_q[`HSI_CTL_CLR_BY_READ])
      command_busy_status_d.interrupt_valid_flag = 1'b0;
    if (lb_wr_command_busy_status)
      command_busy_status_d = lb_req.wdata[7:0];
    if (attention_port_ok)
      command_busy_status_d.busy = 1'b1;
    if (watchdog_evt)
    begin
      command_busy_status_d.rejection_code       = `HSI_REJ_WATCHDOG;
      command_busy_status_d.reject_flag          = 1'b1;
      command_busy_status_d.busy                 = 1'b1;
      command_busy_status_d.interrupt_valid_flag = 1'b1;
    end
    // Held command reset: these bits forced last; rejection code and device bits follow the lines above
    if (cmd_rst)
    begin
      command_busy_status_d.reject_flag          = 1'b0;
      command_busy_status_d.interrupt_valid_flag = 1'b0;
      command_busy_status_d.busy                 = 1'b1;
      if (!(host_wr && host_addr == `HSI_HO_CONTROL))
        ctl_d = `HSI_CTL_CMD_RESET_V;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      command_busy_status_q <= `HSI_COMMAND_BUSY_STATUS_RESET;
      ctl_q  <= 8'h00;
      attention_port_q <= 8'h00;
      isp_q  <= 8'h00;
      cmd_q  <= 32'h0000_0000;
    end
    else
    begin
      command_busy_status_q <= command_busy_status_d;
      ctl_q  <= ctl_d;
      attention_port_q <= attention_port_d;
      isp_q  <= isp_d;
      cmd_q  <= cmd_d;
    end
  end

  // Source id, warm reset flag and NMI status
  always_comb
  begin
    sir_d = sir_q;
    if (lb_wr_sir)
      sir_d = sir_q & lb_req.wdata[15:0]; // Ones ignored
    if (attention_port_ok && move_mode)
      sir_d[host_wdata[3:0]] = 1'b1; // Set beats clear
    if (cmd_rst)
      sir_d = 16'h0000;
    rs_d = rs_q;
    if (host_bus_rst)
      rs_d = 1'b0;
    if (cmd_rst)
      rs_d = 1'b1;
    nmi_d = nmi_q;
    if (lb_rd_nmi)
      nmi_d = 1'b0;
    if (nmi_set)
      nmi_d = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sir_q <= 16'h0000;
      rs_q  <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      sir_q <= sir_d;
      rs_q  <= rs_d;
      nmi_q <= nmi_d;
    end
  end

  // Read data, registered so it lands one cycle after the strobe
  always_comb
  begin
    unique case (host_addr)
      `HSI_HO_ATTENTION:  hrd_d = attention_port_q;
      `HSI_HO_CONTROL:    hrd_d = ctl_q;
      `HSI_HO_INT_STATUS: hrd_d = isp_q;
      `HSI_HO_CMD_BUSY:   hrd_d = command_busy_status_q;
      `HSI_HO_NMI:        hrd_d = {7'h00, nmi_q};
      default:            hrd_d = 8'h00;
    endcase
    if (cmd_rst)
      hrd_d = `HSI_READ_IN_RESET; // Chip held in reset reads all ones
    if (!host_rd)
      hrd_d = hrd_q;
    // Warm flag shows a held command reset from its first cycle on,
    // so a local read in that cycle cannot miss it
    unique case (lb_req.addr)
      `HSI_LB_WARM_RESET: lrd_d = {31'h0000_0000, rs_q || cmd_rst};
      `HSI_LB_NMI:        lrd_d = {31'h0000_0000, nmi_q};
      `HSI_LB_ATTENTION:  lrd_d = {24'h00_0000, attention_port_q};
      `HSI_LB_CONTROL:    lrd_d = {24'h00_0000, ctl_q};
      `HSI_LB_INT_STATUS: lrd_d = {24'h00_0000, isp_q};
      `HSI_LB_CMD_BUSY:   lrd_d = {24'h00_0000, command_busy_status_q};
      `HSI_LB_SOURCE_ID:  lrd_d = {16'h0000, sir_q};
      default:            lrd_d = 32'h0000_0000;
    endcase
    if (!lb_req.rd)
      lrd_d = lrd_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      hrd_q <= 8'h00;
      lrd_q <= 32'h0000_0000;
    end
    else
    begin
      hrd_q <= hrd_d;
      lrd_q <= lrd_d;
    end
  end

  assign host_rdata    = hrd_q;
  assign lb_rdata      = lrd_q;
  assign cmd_word      = cmd_q;
  assign cmd_reset_out = cmd_rst;
  // Host interrupt gated by the enable bit of the control port
  assign host_irq      = command_busy_status_q.interrupt_valid_flag &&
                         ctl_q[`HSI_CTL_IRQ_ENABLE];

  // Local interrupt encoder state
  hsi_pkg::hsi_src_t pend_q, pend_d, batch_q, batch_d;
  hsi_pkg::hsi_src_t raise, clr, inflight, avail;
  logic       cur_v_q, cur_v_d;
  logic [2:0] cur_q, cur_d;
  logic       gen_or, eot_or, free;

  // Event capture, clear actions and priority pick
  always_comb
  begin
    gen_or = |sir_d[7:0];
    eot_or = |sir_d[15:8];
    clr = '0;
    clr[`HSI_SRC_NMI]       = lb_rd_nmi;
    clr[`HSI_SRC_PARITY]    = parity_stat_rd;
    clr[`HSI_SRC_ATTENTION] = lb_rd_attention_port;
    clr[`HSI_SRC_GENERAL]   = lb_wr_sir;
    clr[`HSI_SRC_EOT]       = lb_wr_sir;
    clr[`HSI_SRC_CHAN1]     = chan_stat_rd[0];
    clr[`HSI_SRC_CHAN2]     = chan_stat_rd[1];
    free = !cur_v_q || clr[cur_q]; // Hold until cleared
    inflight = pend_q | batch_q;
    if (cur_v_q && !free)
      inflight[cur_q] = 1'b1;
    raise = '0;
    raise[`HSI_SRC_NMI]       = nmi_set;
    // Level sources re-raise while any bit of their half stays set
    raise[`HSI_SRC_GENERAL]   = gen_or && !inflight[`HSI_SRC_GENERAL];
    raise[`HSI_SRC_EOT]       = eot_or && !inflight[`HSI_SRC_EOT];
    raise[`HSI_SRC_ATTENTION] = attention_port_ok && !move_mode;
    raise[`HSI_SRC_PARITY]    = parity_evt;
    raise[`HSI_SRC_CHAN1]     = chan_evt[0];
    raise[`HSI_SRC_CHAN2]     = chan_evt[1];
    pend_d  = pend_q | raise; // Others wait pending
    batch_d = batch_q;
    cur_v_d = cur_v_q && !free;
    cur_d   = cur_q;
    avail   = '0;
    if (free)
    begin
      // New arrivals join only after the previous batch drains
      if (batch_q == '0)
      begin
        batch_d = pend_d;
        pend_d  = '0;
      end
      avail = batch_d;
      avail[`HSI_SRC_NMI] = batch_d[`HSI_SRC_NMI] || pend_d[`HSI_SRC_NMI];
      // Scanned from the highest code down, last hit wins: NMI, then lowest code
      for (int i = `HSI_NUM_SRC - 1; i >= 0; i--)
      begin
        if (avail[i])
        begin
          cur_v_d = 1'b1;
          cur_d   = 3'(i);
        end
      end
      if (cur_v_d)
      begin
        batch_d[cur_d] = 1'b0;
        pend_d[cur_d]  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pend_q  <= '0;
      batch_q <= '0;
      cur_v_q <= 1'b0;
      cur_q   <= 3'h0;
    end
    else
    begin
      pend_q  <= pend_d;
      batch_q <= batch_d;
      cur_v_q <= cur_v_d;
      cur_q   <= cur_d;
    end
  end

  // Encoded lines idle high when nothing is presented
  assign irq_active = cur_v_q;
  assign irq_lines  = cur_v_q ? {1'b0, cur_q} : `HSI_IRQ_IDLE;

endmodule
`default_nettype wire

//--- hsi_host_model.sv
// Host side model that drives the host port strobes
`timescale 1ns/1ps
`default_nettype none
module hsi_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] host_rdata,
  output logic      [3:0] host_addr,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [7:0] host_wdata
);
  // Idle bus at time zero
  initial {host_addr, host_wr, host_rd, host_wdata} = 14'h0000;

  // Only the host side sets source bits, via attention code D
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk_sys);
    host_wr = 1'b0;
    host_wdata = ~d; // Released data must not look valid
  endtask

  // Read data is taken the cycle after the strobe
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk_sys);
    host_rd = 1'b0;
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

//--- hsi_host_status_asserts.sv
// Concurrent checks on the host status block ports
`timescale 1ns/1ps
`default_nettype none
module hsi_host_status_chk (
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic [3:0]           host_addr,
  input wire logic                 host_wr,
  input wire logic                 host_rd,
  input wire logic [7:0]           host_rdata,
  input wire logic                 cmd_reset_out,
  input wire hsi_pkg::hsi_lb_req_s lb_req,
  input wire logic [31:0]          lb_rdata,
  input wire logic                 watchdog_evt,
  input wire logic [1:0]           chan_evt,
  input wire logic [1:0]           chan_stat_rd,
  input wire logic [3:0]           irq_lines,
  input wire logic                 irq_active
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Line and code relations of the encoder
  AST_IDLE_LINES: assert property (!irq_active |-> irq_lines == 4'hf)
    else $error("idle code wrong");
  AST_RESET_OUT: assert property ($fell(sys_rst) |-> !irq_active)
    else $error("active after reset");
  AST_CHAN_HOLD: assert property (irq_active && irq_lines == 4'h5 &&
    !chan_stat_rd[0] && !cmd_reset_out |=> irq_lines == 4'h5)
    else $error("channel code dropped");
  AST_CHAN_CLEAR: assert property (irq_active && irq_lines == 4'h5 &&
    chan_stat_rd[0] && !chan_evt[0] |=> irq_lines != 4'h5)
    else $error("channel code stuck");
  AST_NMI_READ: assert property (irq_active && irq_lines == 4'h0 &&
    lb_req.rd && lb_req.addr == 32'h1ffa_001c |=> lb_rdata == 32'h0000_0001)
    else $error("nmi status wrong");
  // Host and local reads
  AST_CMDRST_READ: assert property (cmd_reset_out && host_rd &&
    host_addr != 4'h5 |=> host_rdata == 8'hff)
    else $error("read in reset not ff");
  AST_WARM: assert property (cmd_reset_out && lb_req.rd &&
    lb_req.addr == 32'h1ffa_0014 |=> lb_rdata == 32'h0000_0001)
    else $error("warm flag wrong");
  AST_WDOG: assert property (watchdog_evt && !cmd_reset_out ##1
    !host_wr && !lb_req.wr ##1 host_rd && host_addr == 4'h7 && !lb_req.wr
    |=> host_rdata[7:4] == 4'h3)
    else $error("rejection code wrong");

  // Main scenarios reached
  COV_NMI: cover property (irq_active && irq_lines == 4'h0);
  COV_CMDRST: cover property (cmd_reset_out && host_rd);
  COV_WDOG: cover property (watchdog_evt);
endmodule

bind hsi_host_status hsi_host_status_chk u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .host_addr(host_addr),
  .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
  .cmd_reset_out(cmd_reset_out), .lb_req(lb_req), .lb_rdata(lb_rdata),
  .watchdog_evt(watchdog_evt), .chan_evt(chan_evt),
  .chan_stat_rd(chan_stat_rd), .irq_lines(irq_lines),
  .irq_active(irq_active));
`default_nettype wire

//--- hsi_host_status_test.sv
// Self-checking bench for the host status block
`timescale 1ns/1ps
`default_nettype none
`include "hsi_params.svh"
module hsi_host_status_test;
  logic                 clk_sys = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 host_bus_rst = 1'b0;
  logic [6:0]           evv = 7'h00;
  hsi_pkg::hsi_lb_req_s lbq = '0;
  logic [3:0]           host_addr;
  logic                 host_wr;
  logic                 host_rd;
  logic [7:0]           host_wdata;
  logic [7:0]           host_rdata;
  logic [7:0]           rd8;
  logic [31:0]          lb_rdata;
  logic [31:0]          rd32;
  logic [3:0]           irq_lines;
  logic                 irq_active;
  logic                 host_irq;
  logic                 cmd_reset_out;
  logic [31:0]          cmd_word;
  logic [15:0]          rnd = 16'hff3b;
  logic [15:0]          source_identification;
  logic [3:0]           dn;
  int                   err_count = 0;
  int                   n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  hsi_host_model u_hsi_host_model (.clk_sys(clk_sys),
    .host_rdata(host_rdata), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata));
  hsi_host_status u_hsi_host_status (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .host_bus_rst(host_bus_rst), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_irq(host_irq), .cmd_reset_out(cmd_reset_out),
    .cmd_word(cmd_word), .lb_req(lbq),
    .lb_rdata(lb_rdata), .watchdog_evt(evv[0]), .parity_evt(evv[1]),
    .parity_stat_rd(evv[2]), .chan_evt(evv[4:3]), .chan_stat_rd(evv[6:5]),
    .irq_lines(irq_lines), .irq_active(irq_active));

  // Expectation helpers
  function automatic logic [15:0] xs(input logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    return x ^ (x << 8);
  endfunction
  function automatic logic [3:0] sir_code(input logic [15:0] s);
    return |s[7:0] ? 4'h1 : (|s[15:8] ? 4'h2 : 4'hf);
  endfunction
  task automatic cmp(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Bus and event drivers, all on the falling edge
  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    u_hsi_host_model.put(a, d);
  endtask
  task automatic lw(input logic [31:0] a, d);
    @(negedge clk_sys);
    lbq = '{a, 1'b1, 1'b0, d};
    @(negedge clk_sys);
    lbq.wr = 1'b0;
  endtask
  task automatic lchk(input logic [31:0] a, e);
    @(negedge clk_sys);
    lbq = '{a, 1'b0, 1'b1, 32'h0000_0000};
    @(negedge clk_sys);
    lbq.rd = 1'b0;
    cmp("lb_rdata", lb_rdata, e);
  endtask
  task automatic hchk(input logic [3:0] a, input logic [7:0] e);
    u_hsi_host_model.get(a, rd8);
    cmp("host_rdata", {24'h0, rd8}, {24'h0, e});
  endtask
  task automatic pulse(input logic [6:0] v);
    @(negedge clk_sys);
    evv = v;
    @(negedge clk_sys);
    evv = 7'h00;
  endtask
  // Lines settle within a cycle; three gives margin
  task automatic lines(input logic [3:0] e);
    repeat (3) @(negedge clk_sys);
    cmp("irq_lines", {28'h0, irq_lines}, {28'h0, e});
    cmp("irq_active", {31'h0, irq_active}, {31'h0, e != 4'hf});
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    hchk(4'h7, 8'h01);
    lchk(`HSI_LB_SOURCE_ID, 32'h0);
    lchk(`HSI_LB_WARM_RESET, 32'h0);
    hw(4'hb, 8'h00);
    lines(4'hf);
    lchk(`HSI_LB_NMI, 32'h0);
    // Bits 0 and 15 then a random one; busy released before each
    source_identification = 16'h0000;
    for (int i = 0; i < 3; i++)
    begin
      rnd = xs(rnd);
      dn = (i == 0) ? 4'h0 : ((i == 1) ? 4'hf : rnd[3:0]);
      hw(4'h5, 8'h20);
      hw(4'h4, {4'hd, dn});
      source_identification[dn] = 1'b1;
    end
    hw(4'h4, 8'hd5); // Busy, so ignored
    hw(4'h0, 8'ha5); // Command byte also blocked while busy
    cmp("cmd_word", cmd_word, 32'h0000_0000);
    lchk(`HSI_LB_SOURCE_ID, {16'h0, source_identification});
    lines(sir_code(source_identification));
    lw(`HSI_LB_SOURCE_ID, 32'h0000_ffff);
    lchk(`HSI_LB_SOURCE_ID, {16'h0, source_identification});
    lw(`HSI_LB_SOURCE_ID, 32'h0000_fffe);
    source_identification[0] = 1'b0;
    // Bit 3 keeps general raised, but it waits pending while end-of-transfer from the batch goes next
    lines(4'h2);
    lw(`HSI_LB_SOURCE_ID, 32'h0);
    lw(`HSI_LB_SOURCE_ID, 32'h0);
    lines(4'hf);
    // Parity and both channels at once, NMI then overtakes the batch
    pulse(7'h1a);
    lines(4'h4);
    pulse(7'h04);
    lines(4'h5);
    hw(4'hb, rnd[7:0] | 8'h01);
    lines(4'h5);
    pulse(7'h20);
    lines(4'h0);
    pulse(7'h08);
    lchk(`HSI_LB_NMI, 32'h1);
    lines(4'h6);
    pulse(7'h40);
    lines(4'h5);
    pulse(7'h20);
    lines(4'hf);
    // Watchdog reject; only code D passes it
    hw(4'h5, 8'h01);
    pulse(7'h01);
    hchk(4'h7, 8'h33);
    cmp("host_irq", {31'h0, host_irq}, 32'h1);
    hw(4'h1, 8'h3c);
    cmp("cmd_word", cmd_word, 32'h0000_0000);
    hw(4'h4, 8'h10);
    lines(4'hf);
    hw(4'h4, 8'hd1);
    lines(4'h1);
    hw(4'h5, 8'h21);
    hchk(4'h7, 8'h22);
    hw(4'h3, rnd[15:8]);
    cmp("cmd_word", cmd_word, {rnd[15:8], 24'h00_0000});
    hw(4'h4, 8'he0);
    hchk(4'h7, 8'h21);
    cmp("host_irq", {31'h0, host_irq}, 32'h0);
    lw(`HSI_LB_SOURCE_ID, 32'h0);
    lines(4'h3);
    lchk(`HSI_LB_ATTENTION, 32'h0000_00e0);
    lines(4'hf);
    // Valid flag cleared by reading status
    hw(4'h5, 8'h61);
    pulse(7'h01);
    hchk(4'h7, 8'h33);
    hchk(4'h7, 8'h31);
    // Command reset, then host bus reset
    hw(4'h5, 8'h80);
    hchk(4'h7, 8'hff);
    cmp("cmd_reset_out", {31'h0, cmd_reset_out}, 32'h1);
    lchk(`HSI_LB_WARM_RESET, 32'h1);
    lchk(`HSI_LB_SOURCE_ID, 32'h0);
    hw(4'h5, 8'h00);
    hchk(4'h7, 8'h21);
    cmp("cmd_reset_out", {31'h0, cmd_reset_out}, 32'h0);
    @(negedge clk_sys);
    host_bus_rst = 1'b1;
    @(negedge clk_sys);
    host_bus_rst = 1'b0;
    lchk(`HSI_LB_WARM_RESET, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
